// *** hdl/revm_ctrl.sv ***
`default_nettype none

module revm_ctrl
    import revm_pkg::*;
#(
    parameter bit HAS_BUS_CTRL = 1'b1,   // Variant carries the bus controller
    parameter bit HAS_MOTOR = 1'b1       // Variant carries motor-control pwm
) (
    // Clock, reset and enable
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clk_en,
    // Peripheral events, indexed by request number
    input wire logic [NUM_IRQ-1:0] src_event,
    // Software side of flags, enables and priorities
    input wire logic [FLAG_W-1:0] sw_flag_clr,
    input wire logic [FLAG_W-1:0] request_enable_regs,
    input wire logic [PRIO_REGS*REG_W-1:0] request_priority_regs,
    // Vector table write port
    input wire logic table_wr_en,
    input wire logic [VEC_W-1:0] table_wr_vector,
    input wire logic [ADDR_W-1:0] table_wr_handler,
    // Flag state
    output logic [FLAG_W-1:0] request_flag_regs_q,
    // Request toward the core
    output logic pending_valid_q,
    output logic [VEC_W-1:0] pending_vector_q,
    output logic [PRIO_FIELD_W-1:0] pending_level_q,
    output logic [ADDR_W-1:0] pending_table_addr_q,
    output logic [ADDR_W-1:0] handler_addr_q,
    // Reset entry toward the core
    output logic reset_entry_q,
    output logic [ADDR_W-1:0] restart_pc_q
);

    // ---------------------------------------------------------------
    // Helper functions
    // ---------------------------------------------------------------

    // Vector of a request number
    function automatic logic [VEC_W-1:0] irq_to_vector(input int n);
        return VEC_W'(n + VEC_OFFSET);
    endfunction

    // Program address of a vector's table entry
    function automatic logic [ADDR_W-1:0] table_addr(input logic [VEC_W-1:0] v);
        return ADDR_W'(int'(v) * TABLE_STEP + TABLE_BASE);
    endfunction

    // Flat position of a flag or enable bit: register n/16, bit n%16
    function automatic int flag_pos(input int n);
        return (n / REG_W) * REG_W + (n % REG_W);
    endfunction

    // Flat position of a priority field's low bit
    function automatic int prio_pos(input int n);
        return (n / PRIO_PER_REG) * REG_W + (n % PRIO_PER_REG) * PRIO_FIELD_STEP;
    endfunction

    // ---------------------------------------------------------------
    // Variant mask
    // ---------------------------------------------------------------

    // Sources missing from the variant behave as reserved
    localparam logic [63:0] ACTIVE_MASK = IMPL_MASK
        & (HAS_BUS_CTRL ? 64'hffff_ffff_ffff_ffff : ~BUS_CTRL_MASK)
        & (HAS_MOTOR ? 64'hffff_ffff_ffff_ffff : ~MOTOR_MASK);

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    revm_phase_e phase_q;                 // Entry cycle after reset, then run
    logic [FLAG_W-1:0] flag_d;            // Next flag value
    logic [FLAG_W-1:0] event_flat;        // Events placed at flag positions
    logic best_valid;                     // Some source is pending
    logic [5:0] best_irq;                 // Winning request number
    logic [PRIO_FIELD_W-1:0] best_lvl;    // Winning level
    logic [PRIO_FIELD_W-1:0] lvl;         // Level under inspection
    logic [ADDR_W-1:0] handler_mem [NUM_IRQ]; // Handler addresses by request
    logic [VEC_W-1:0] best_vec;           // Vector of the winner
    logic tbl_hit;                        // Table write lands on a user vector

    // ---------------------------------------------------------------
    // Reset entry phase
    // ---------------------------------------------------------------

    // One entry cycle after reset release, the core restarts at zero
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            phase_q <= REVM_PH_ENTRY;
        end else if (clk_en) begin
            phase_q <= REVM_PH_RUN;
        end
    end

    // Restart indication is a plain reset path, no vectoring involved
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reset_entry_q <= 1'b1;
            restart_pc_q <= RESET_PC;
        end else if (clk_en) begin
            reset_entry_q <= 1'b0; // Entry edge taken, core runs from here
            restart_pc_q <= RESET_PC;
        end
    end

    // ---------------------------------------------------------------
    // Request flags
    // ---------------------------------------------------------------

    // Events scattered into the flat flag layout
    always_comb begin
        event_flat = '0;
        for (int n = 0; n < NUM_IRQ; n++) begin
            event_flat[flag_pos(n)] = src_event[n];
        end
    end

    // Set beats clear in the same cycle so no event is lost
    always_comb begin
        flag_d = ((request_flag_regs_q & ~sw_flag_clr) | event_flat) & ACTIVE_MASK;
    end

    // Flags clear on reset and update only while enabled
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            request_flag_regs_q <= FLAG_RESET;
        end else if (clk_en) begin
            request_flag_regs_q <= flag_d;
        end
    end

    // ---------------------------------------------------------------
    // Arbitration
    // ---------------------------------------------------------------

    // Highest level wins; ties keep the lowest request, which has the
    // lowest table address, because only a strictly higher level displaces
    always_comb begin
        best_valid = 1'b0;
        best_irq = '0;
        best_lvl = '0;
        lvl = '0;
        for (int n = 0; n < NUM_IRQ; n++) begin
            lvl = request_priority_regs[prio_pos(n) +: PRIO_FIELD_W];
            if (ACTIVE_MASK[flag_pos(n)] && request_flag_regs_q[flag_pos(n)]
                && request_enable_regs[flag_pos(n)]) begin
                if (!best_valid || lvl > best_lvl) begin
                    best_valid = 1'b1;
                    best_irq = 6'(n);
                    best_lvl = lvl;
                end
            end
        end
    end

    // Vector of the winner
    always_comb begin
        best_vec = irq_to_vector(int'(best_irq));
    end

    // Pending request registered toward the core; silent in entry cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pending_valid_q <= 1'b0;
            pending_vector_q <= '0;
            pending_level_q <= '0;
            pending_table_addr_q <= '0;
        end else if (clk_en) begin
            pending_valid_q <= best_valid && (phase_q == REVM_PH_RUN);
            pending_vector_q <= best_vec;
            pending_level_q <= best_lvl;
            pending_table_addr_q <= table_addr(best_vec);
        end
    end

    // ---------------------------------------------------------------
    // Vector table
    // ---------------------------------------------------------------

    // Only user vectors 8..65 are stored here
    always_comb begin
        tbl_hit = (int'(table_wr_vector) >= VEC_OFFSET) && (int'(table_wr_vector) <= LAST_VECTOR);
    end

    // Table lives in program memory, so reset leaves it alone
    always_ff @(posedge sys_clk) begin
        if (clk_en && table_wr_en && tbl_hit) begin
            handler_mem[6'(int'(table_wr_vector) - VEC_OFFSET)] <= table_wr_handler;
        end
    end

    // Handler of the current winner, presented beside the vector
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            handler_addr_q <= '0;
        end else if (clk_en) begin
            handler_addr_q <= handler_mem[best_irq];
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------

    // Reset forces restart at zero and an entry cycle
    a_reset_pc_zero: assert property (@(posedge sys_clk) disable iff (1'b0)
        srst |=> reset_entry_q && restart_pc_q == 24'h00_0000 && request_flag_regs_q == 64'h0)
        else $error("reset did not clear state or restart at zero");

    // No vector during or right after reset
    a_reset_no_vector: assert property (@(posedge sys_clk) disable iff (1'b0)
        srst ##1 (!srst && clk_en) |=> !pending_valid_q)
        else $error("vector raised for reset");

    // First fetch address after release is zero
    a_restart_addr: assert property (@(posedge sys_clk) disable iff (srst)
        reset_entry_q |-> restart_pc_q == 24'h00_0000 && !pending_valid_q)
        else $error("restart address not zero");

    // Vector lies inside the covered user range, 8 to 65
    a_vector_range: assert property (@(posedge sys_clk) disable iff (srst)
        pending_valid_q |-> pending_vector_q >= 8'h08 && pending_vector_q <= 8'h41)
        else $error("vector outside user range");

    // Table address tied to the vector
    a_table_addr_map: assert property (@(posedge sys_clk) disable iff (srst)
        pending_valid_q |-> pending_table_addr_q == {15'h0, pending_vector_q, 1'b0} + 24'h4)
        else $error("table address mismatch");

    // Reserved and absent sources never flag
    a_reserved_no_flag: assert property (@(posedge sys_clk) disable iff (srst)
        (request_flag_regs_q & ~ACTIVE_MASK) == 64'h0)
        else $error("flag set on reserved source");

    // An event in the clearing cycle still sets the flag
    a_flag_set_wins: assert property (@(posedge sys_clk) disable iff (srst)
        clk_en && src_event[0] && sw_flag_clr[0] |=> request_flag_regs_q[0])
        else $error("event lost against clear");

    // No enable, no pending
    a_pending_needs_enable: assert property (@(posedge sys_clk) disable iff (srst)
        clk_en && request_enable_regs == 64'h0 |=> !pending_valid_q)
        else $error("pending without enable");

    // External request zero alone maps to vector 8 at 0x14
    a_ext0_vector: assert property (@(posedge sys_clk) disable iff (srst)
        clk_en && phase_q == REVM_PH_RUN && request_flag_regs_q == 64'h1
        && request_enable_regs[0]
        |=> pending_valid_q && pending_vector_q == 8'h08 && pending_table_addr_q == 24'h00_0014)
        else $error("external request zero mis-mapped");

    // Equal levels: request 0 beats request 1
    a_tie_lower_vector: assert property (@(posedge sys_clk) disable iff (srst)
        clk_en && phase_q == REVM_PH_RUN && request_flag_regs_q[1:0] == 2'b11
        && request_enable_regs[1:0] == 2'b11
        && request_priority_regs[2:0] == request_priority_regs[6:4]
        && request_priority_regs[2:0] == 3'h7
        |=> pending_vector_q == 8'h08)
        else $error("tie not resolved to lower vector");

    // Main scenarios
    c_pwm_match: cover property (@(posedge sys_clk) disable iff (srst)
        pending_valid_q && pending_vector_q == 8'h41);
    c_reset_entry: cover property (@(posedge sys_clk)
        srst ##1 !srst ##1 !reset_entry_q);
    c_level_seven: cover property (@(posedge sys_clk) disable iff (srst)
        pending_valid_q && pending_level_q == 3'h7);
    c_flag_cleared: cover property (@(posedge sys_clk) disable iff (srst)
        request_flag_regs_q[0] ##1 !request_flag_regs_q[0]);

endmodule

`default_nettype wire

// *** hdl/revm_pkg.sv ***
`default_nettype none

package revm_pkg;

    // ---------------------------------------------------------------
    // Source map geometry
    // ---------------------------------------------------------------
    localparam int NUM_IRQ = 58;               // Request numbers 0..57
    localparam int VEC_OFFSET = 8;             // Request number plus this is the vector
    localparam int LAST_VECTOR = 65;           // Highest vector covered here
    localparam int TABLE_BASE = 4;             // Table address of vector 0
    localparam int TABLE_STEP = 2;             // Program addresses per entry
    localparam int FLAG_W = 64;                // Four flag/enable registers of 16 bits
    localparam int REG_W = 16;                 // Bits per flag, enable or priority register
    localparam int PRIO_REGS = 15;             // Priority registers 0..14
    localparam int PRIO_FIELD_W = 3;           // Eight levels per source
    localparam int PRIO_FIELD_STEP = 4;        // Fields at 2:0, 6:4, 10:8, 14:12
    localparam int PRIO_PER_REG = 4;           // Fields per priority register
    localparam int ADDR_W = 24;                // Program address and handler width
    localparam int VEC_W = 8;                  // Vector number width

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [23:0] RESET_PC = 24'h00_0000;
    localparam logic [63:0] FLAG_RESET = 64'h0000_0000_0000_0000;

    // ---------------------------------------------------------------
    // Implemented requests (all others are reserved)
    // ---------------------------------------------------------------
    localparam logic [63:0] IMPL_MASK = 64'h0206_007f_ff1f_7fff;
    localparam logic [63:0] BUS_CTRL_MASK = 64'h0000_000c_0000_0000;
    localparam logic [63:0] MOTOR_MASK = 64'h0200_0000_0000_0000;

    // ---------------------------------------------------------------
    // Vector numbers of named sources
    // ---------------------------------------------------------------
    localparam int VEC_EXTERNAL_REQUEST_ZERO = 8;
    localparam int VEC_CAPTURE_UNIT_FIRST = 9;
    localparam int VEC_COMPARE_UNIT_FIRST = 10;
    localparam int VEC_TRANSFER_CHANNEL_FIRST = 12;
    localparam int VEC_SYNC_PORT_FIRST_ERROR = 17;
    localparam int VEC_SYNC_PORT_FIRST_DONE = 18;
    localparam int VEC_SERIAL_FIRST_RECEIVE = 19;
    localparam int VEC_SERIAL_FIRST_TRANSMIT = 20;
    localparam int VEC_CONVERTER_DONE = 21;
    localparam int VEC_TRANSFER_CHANNEL_SECOND = 22;
    localparam int VEC_COMPARATOR_EVENT = 26;
    localparam int VEC_PIN_CHANGE_EVENT = 27;
    localparam int VEC_EXTERNAL_REQUEST_ONE = 28;
    localparam int VEC_TRANSFER_CHANNEL_THIRD = 32;
    localparam int VEC_EXTERNAL_REQUEST_TWO = 37;
    localparam int VEC_BUS_RECEIVE_READY = 42;
    localparam int VEC_BUS_CONTROLLER_EVENT = 43;
    localparam int VEC_TRANSFER_CHANNEL_LAST = 44;
    localparam int VEC_TWOWIRE_SECOND_TARGET = 57;
    localparam int VEC_TWOWIRE_SECOND_CONTROLLER = 58;
    localparam int VEC_PWM_SPECIAL_MATCH = 65;

    // ---------------------------------------------------------------
    // Entry phase after reset
    // ---------------------------------------------------------------
    typedef enum logic [0:0] {
        REVM_PH_ENTRY = 1'b0,
        REVM_PH_RUN = 1'b1
    } revm_phase_e;

endpackage

`default_nettype wire

// *** testbench/revm_core_model.sv ***
`default_nettype none

module revm_core_model
    import revm_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clk_en,
    // Reset entry from the block
    input wire logic reset_entry_q,
    input wire logic [ADDR_W-1:0] restart_pc_q,
    // Handler table write port
    output logic table_wr_en,
    output logic [VEC_W-1:0] table_wr_vector,
    output logic [ADDR_W-1:0] table_wr_handler,
    // Status seen by the bench
    output logic table_done,
    output logic [ADDR_W-1:0] fetch_pc
);
    timeunit 1ns;
    timeprecision 100ps;

    // Default handler whose body issues a software reset
    localparam logic [ADDR_W-1:0] DEFAULT_HANDLER = 24'h000200;

    // ---------------------------------------------------------------
    // Program image
    // ---------------------------------------------------------------
    // Unused or reserved entries land in the resetting default handler
    assign table_wr_handler = IMPL_MASK[table_wr_vector - 8'h08] ?
        {16'h0100, table_wr_vector} : DEFAULT_HANDLER;

    // One entry per enabled edge; a write is held until clk_en takes it
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            table_wr_en <= 1'b0;
            table_wr_vector <= 8'h08;
            table_done <= 1'b0;
        end else if (!reset_entry_q && !table_done && (!table_wr_en || clk_en)) begin
            if (table_wr_en && table_wr_vector == 8'h41) begin
                table_wr_en <= 1'b0;
                table_done <= 1'b1;
            end else begin
                table_wr_en <= 1'b1;
                table_wr_vector <= table_wr_vector + {7'h00, table_wr_en};
            end
        end
    end

    // First fetch comes from the restart address, where the start-up jump sits
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            fetch_pc <= 24'hffffff;
        end else if (clk_en && reset_entry_q) begin
            fetch_pc <= restart_pc_q;
        end
    end
endmodule

`default_nettype wire

// *** testbench/reset_entry_and_vector_map_tb.sv ***
`default_nettype none

module reset_entry_and_vector_map_tb
    import revm_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    // Stimulus and observed signals
    logic sys_clk, srst, clk_en, rand_en, pending_valid_q, reset_entry_q;
    logic table_wr_en, table_done;
    logic [NUM_IRQ-1:0] src_event;
    logic [FLAG_W-1:0] sw_flag_clr, request_enable_regs, request_flag_regs_q, var_flags;
    logic [PRIO_REGS*REG_W-1:0] request_priority_regs;
    logic [VEC_W-1:0] table_wr_vector, pending_vector_q;
    logic [PRIO_FIELD_W-1:0] pending_level_q;
    logic [ADDR_W-1:0] table_wr_handler, pending_table_addr_q, handler_addr_q;
    logic [ADDR_W-1:0] restart_pc_q, fetch_pc;
    // Bookkeeping
    int seed = 32'h01c6;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    int best;
    logic [63:0] mask, exp_flags;

    // ---------------------------------------------------------------
    // Design, reduced variant and core model
    // ---------------------------------------------------------------
    revm_ctrl dut_u (.sys_clk, .srst, .clk_en, .src_event, .sw_flag_clr,
        .request_enable_regs, .request_priority_regs, .table_wr_en, .table_wr_vector,
        .table_wr_handler, .request_flag_regs_q, .pending_valid_q, .pending_vector_q,
        .pending_level_q, .pending_table_addr_q, .handler_addr_q, .reset_entry_q,
        .restart_pc_q);
    // Variant without bus controller and motor pwm; only its flags are watched
    revm_ctrl #(.HAS_BUS_CTRL(1'b0), .HAS_MOTOR(1'b0)) dut_v (.sys_clk, .srst, .clk_en,
        .src_event, .sw_flag_clr, .request_enable_regs, .request_priority_regs,
        .table_wr_en, .table_wr_vector, .table_wr_handler, .request_flag_regs_q(var_flags),
        .pending_valid_q(), .pending_vector_q(), .pending_level_q(),
        .pending_table_addr_q(), .handler_addr_q(), .reset_entry_q(), .restart_pc_q());
    revm_core_model core_u (.sys_clk, .srst, .clk_en, .reset_entry_q, .restart_pc_q,
        .table_wr_en, .table_wr_vector, .table_wr_handler, .table_done, .fetch_pc);

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Implemented request numbers of the source map
    function automatic logic impl(input int n);
        return n <= 14 || (n >= 16 && n <= 20) || (n >= 24 && n <= 38) ||
            n == 49 || n == 50 || n == 57;
    endfunction

    // Priority field of request n
    function automatic logic [2:0] lvl(input int n);
        return request_priority_regs[(n / 4) * 16 + (n % 4) * 4 +: 3];
    endfunction

    task automatic chk_bit(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic chk_word(input logic [63:0] got, input logic [63:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Waits for the next enabled edge; clk_en is redrawn after every edge
    task automatic tick();
        logic was;
        do begin
            @(posedge sys_clk);
            was = clk_en;
            #1;
            clk_en = rand_en ? ($random(seed) % 3 != 0) : 1'b1;
        end while (!was);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Reset with an event pending, then the entry edge and the first request
    task automatic do_reset(input int cycles);
        rand_en = 1'b0;
        clk_en = 1'b1;
        srst = 1'b1;
        src_event = '0;
        src_event[0] = 1'b1;
        request_enable_regs = '1;
        request_priority_regs = '0;
        repeat (cycles) @(posedge sys_clk);
        #1;
        chk_word(request_flag_regs_q, 64'h0, "flags in reset");
        chk_bit(reset_entry_q, 1'b1, "entry in reset");
        chk_bit(pending_valid_q, 1'b0, "pending in reset");
        chk_word(restart_pc_q, 64'h0, "restart pc");
        srst = 1'b0;
        tick();
        chk_bit(reset_entry_q, 1'b0, "entry released");
        chk_bit(pending_valid_q, 1'b0, "pending in entry");
        chk_word(request_flag_regs_q, 64'h1, "flag after entry");
        src_event = '0;
        tick();
        chk_bit(pending_valid_q, 1'b1, "first pending");
        chk_word(pending_vector_q, 64'h8, "first vector");
        chk_word(fetch_pc, 64'h0, "first fetch");
        sw_flag_clr = '1;
        tick();
        sw_flag_clr = '0;
        tick();
        // Event and clear in one cycle: the set must win
        src_event[0] = 1'b1;
        sw_flag_clr = '1;
        tick();
        chk_word(request_flag_regs_q, 64'h1, "set beats clear");
        src_event = '0;
        tick();
        sw_flag_clr = '0;
        chk_word(request_flag_regs_q, 64'h0, "clear alone");
    endtask

    // ---------------------------------------------------------------
    // Clock, timeout and main sequence
    // ---------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Ceiling well above the roughly one thousand cycles the sequence needs
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            $display("ERROR %0t: run timed out", $time);
            close_out();
        end
    end

    initial begin
        sw_flag_clr = '0;
        do_reset(8);
        for (int i = 0; i < 400 && !table_done; i++) tick();
        chk_bit(table_done, 1'b1, "table programmed");
        rand_en = 1'b1;
        // Sweep every request number with random enables and priorities
        for (int i = 0; i < PRIO_REGS; i++) request_priority_regs[i*16 +: 16] = 16'($random(seed));
        for (int n = 0; n < NUM_IRQ; n++) begin
            request_enable_regs[n] = 1'($random(seed));
            src_event[n] = 1'b1;
            tick();
            src_event[n] = 1'b0;
            tick();
            exp_flags = impl(n) ? 64'h1 << n : 64'h0;
            chk_word(request_flag_regs_q, exp_flags, "flag position");
            chk_word(var_flags, (n == 34 || n == 35 || n == 57) ? 64'h0 : exp_flags,
                "variant flag");
            chk_bit(pending_valid_q, impl(n) && request_enable_regs[n], "gate");
            if (impl(n) && request_enable_regs[n]) begin
                chk_word(pending_vector_q, 64'(n + 8), "vector");
                chk_word(pending_vector_q, 64'(n + 8), "named");
                chk_word(pending_table_addr_q, 64'(2 * (n + 8) + 4), "table addr");
                chk_word(pending_level_q, 64'(lvl(n)), "level");
                chk_word(handler_addr_q, 64'(24'h010000 | (n + 8)), "handler");
            end
            sw_flag_clr = '1;
            tick();
            sw_flag_clr = '0;
            tick();
            chk_word(request_flag_regs_q, 64'h0, "flag cleared");
        end
        // All flags up with every enable low: nothing may be forwarded
        request_enable_regs = '0;
        src_event = '1;
        tick();
        src_event = '0;
        tick();
        chk_bit(pending_valid_q, 1'b0, "no enable");
        sw_flag_clr = '1;
        tick();
        sw_flag_clr = '0;
        // Arbitration rounds; round zero a level-zero tie, round one a level-seven tie
        request_enable_regs = '1;
        for (int r = 0; r < 16; r++) begin
            for (int i = 0; i < PRIO_REGS; i++) begin
                request_priority_regs[i*16 +: 16] = (r == 0) ? 16'h0000 :
                    (r == 1) ? 16'h7777 : 16'($random(seed));
            end
            mask = {$random(seed), $random(seed)} & {$random(seed), $random(seed)};
            if (r == 0) mask = 64'h0000_0004_0000_0010;
            if (r == 1) mask = 64'h0000_0000_0000_0003;
            src_event = mask[NUM_IRQ-1:0];
            for (int n = 0; n < 64; n++) if (n >= NUM_IRQ || !impl(n)) mask[n] = 1'b0;
            tick();
            src_event = '0;
            tick();
            while (mask != 64'h0) begin
                best = -1;
                for (int n = 0; n < NUM_IRQ; n++) begin
                    if (mask[n] && (best < 0 || lvl(n) > lvl(best))) best = n;
                end
                chk_bit(pending_valid_q, 1'b1, "pending held");
                chk_word(pending_vector_q, 64'(best + 8), "winner");
                sw_flag_clr[best] = 1'b1;
                mask[best] = 1'b0;
                tick();
                sw_flag_clr = '0;
                tick();
            end
            chk_bit(pending_valid_q, 1'b0, "pending drained");
        end
        // Second reset in mid-run with every flag set
        src_event = '1;
        tick();
        do_reset(2);
        close_out();
    end
endmodule

`default_nettype wire
